// [verilog/ddio_cfg.svh]
`ifndef DDIO_CFG_SVH
`define DDIO_CFG_SVH
// Summary of operation
// - Debounce inputs, 0 to 1000 ms, default 10.
// - Virtual enable bits 0-3 select software value.
// - Bit 4 fast_input_a, bit 8 fast_input_b.
// - Wiring mode field 0..3, default 0.
// - Per-input switch-on delay, 0 to 50000 ms.
// - Per-input switch-off delay, 0 to 50000 ms.
// - Snapshot inputs when fault appears; readable.
// - Conditioned input state readable by software.
// - Four outputs, each with own function select.
// - Fast output: pulse mode or digital mode.
// - Same function code allowed on several outputs.
// - Function code 0 keeps output off.
// - Codes 1-4: running, forward, reverse, jogging.
// - Code 5: on while drive fault present.
// - Code 9: output and reference frequency zero.
// - Code 10: upper limit frequency reached.
// - Code 11: lower limit frequency reached.
// - Code 12: powers up, no protection active.
// - Code 13: on during pre-excitation.
// - Code 14: overload pre-alarm time elapsed.
// - Per-input polarity inversion field, default 0.
`define DDIO_NUM_IN 6
`define DDIO_NUM_OUT 4
`define DDIO_CLK_PERIOD_NS 5
`define DDIO_MS_NS 1000000
`define DDIO_MS_CYCLES (`DDIO_MS_NS / `DDIO_CLK_PERIOD_NS)
`define DDIO_ADDR_FILTER 8'h00
`define DDIO_ADDR_VIRT_EN 8'h01
`define DDIO_ADDR_WIRING 8'h02
`define DDIO_ADDR_POLARITY 8'h03
`define DDIO_ADDR_VIRT_VAL 8'h04
`define DDIO_ADDR_FSEL0 8'h05
`define DDIO_ADDR_FAST_MODE 8'h09
`define DDIO_ADDR_DELAY_HI 4'h1
`define DDIO_ADDR_SNAPSHOT 8'h20
`define DDIO_ADDR_LIVE 8'h21
`define DDIO_FILTER_RST 16'h000a
`define DDIO_FILTER_MAX 16'h03e8
`define DDIO_DELAY_MAX 16'hc350
`define DDIO_VIRT_A_BIT 4
`define DDIO_VIRT_B_BIT 8
`define DDIO_FN_NONE 6'h00
`define DDIO_FN_RUN 6'h01
`define DDIO_FN_FWD 6'h02
`define DDIO_FN_REV 6'h03
`define DDIO_FN_JOG 6'h04
`define DDIO_FN_FAULT 6'h05
`define DDIO_FN_LEVEL_ONE 6'h06
`define DDIO_FN_LEVEL_TWO 6'h07
`define DDIO_FN_REACHED 6'h08
`define DDIO_FN_ZERO 6'h09
`define DDIO_FN_UPPER 6'h0a
`define DDIO_FN_LOWER 6'h0b
`define DDIO_FN_READY 6'h0c
`define DDIO_FN_PREEXC 6'h0d
`define DDIO_FN_OVLD 6'h0e
`endif

// [verilog/ddio_pkg.sv]
package ddio_pkg;
    typedef logic [5:0] ddio_fsel_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } ddio_bus_s;
    typedef struct packed {
        logic running;
        logic fwd;
        logic rev;
        logic jog;
        logic freq_out;
        logic fault;
        logic freq_level_detect_one;
        logic freq_level_detect_two;
        logic freq_reached;
        logic ref_zero;
        logic at_upper;
        logic at_lower;
        logic main_pwr;
        logic ctrl_pwr;
        logic prot_active;
        logic preexcite;
        logic overload_pre;
    } ddio_status_s;
endpackage

// [verilog/ddio_top.sv]
`timescale 1ns/1ps
`include "ddio_cfg.svh"
module ddio_top #(
    parameter int unsigned MS_CYCLES = `DDIO_MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire ddio_pkg::ddio_bus_s bus_i,
    output logic [15:0] rdata_o,
    input wire logic [5:0] pins_i,
    input wire ddio_pkg::ddio_status_s status_i,
    input wire logic pulse_i,
    output logic [5:0] cond_inputs_o,
    output logic [1:0] wiring_mode_o,
    output logic relay_one_o,
    output logic relay_two_o,
    output logic collector_output_o,
    output logic fast_pulse_out_o
);
    localparam int NI = `DDIO_NUM_IN;
    localparam int NO = `DDIO_NUM_OUT;

    function automatic logic fn_active(input ddio_pkg::ddio_fsel_t code,
                                       input ddio_pkg::ddio_status_s s);
        case (code)
            `DDIO_FN_RUN: fn_active = s.running && s.freq_out;
            `DDIO_FN_FWD: fn_active = s.fwd && s.freq_out;
            `DDIO_FN_REV: fn_active = s.rev && s.freq_out;
            `DDIO_FN_JOG: fn_active = s.jog && s.freq_out;
            `DDIO_FN_FAULT: fn_active = s.fault;
            `DDIO_FN_LEVEL_ONE: fn_active = s.freq_level_detect_one;
            `DDIO_FN_LEVEL_TWO: fn_active = s.freq_level_detect_two;
            `DDIO_FN_REACHED: fn_active = s.freq_reached;
            `DDIO_FN_ZERO: fn_active = !s.freq_out && s.ref_zero;
            `DDIO_FN_UPPER: fn_active = s.at_upper;
            `DDIO_FN_LOWER: fn_active = s.at_lower;
            `DDIO_FN_READY: fn_active = s.main_pwr && s.ctrl_pwr && !s.prot_active;
            `DDIO_FN_PREEXC: fn_active = s.preexcite;
            `DDIO_FN_OVLD: fn_active = s.overload_pre;
            default: fn_active = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] max);
        clamp = (v > max) ? max : v;
    endfunction

    logic [5:0] meta_reg;
    logic [5:0] sync_reg;
    logic [31:0] tick_cnt_reg;
    logic tick_reg;
    logic [15:0] filter_time_reg;
    logic [5:0] virt_en_reg;
    logic [5:0] virt_val_reg;
    logic [1:0] wiring_reg;
    logic [5:0] polarity_reg;
    ddio_pkg::ddio_fsel_t fsel_reg [NO];
    logic fast_mode_reg;
    logic [15:0] on_dly_reg [NI];
    logic [15:0] off_dly_reg [NI];
    logic [5:0] filt_reg;
    logic [5:0] dly_reg;
    logic [5:0] snap_reg;
    logic fault_q_reg;
    logic [3:0] out_reg;
    logic [15:0] rdata_reg;
    logic [5:0] filt_accept;
    logic [5:0] tgt;
    logic [5:0] dly_accept;

    wire [7:0] a = bus_i.addr;
    wire wr_filter = bus_i.wr && a == `DDIO_ADDR_FILTER;
    wire wr_virt_en = bus_i.wr && a == `DDIO_ADDR_VIRT_EN;
    wire wr_virt_val = bus_i.wr && a == `DDIO_ADDR_VIRT_VAL;
    wire wr_wiring = bus_i.wr && a == `DDIO_ADDR_WIRING;
    wire wr_polarity = bus_i.wr && a == `DDIO_ADDR_POLARITY;
    wire wr_fast = bus_i.wr && a == `DDIO_ADDR_FAST_MODE;
    wire fsel_hit = a >= `DDIO_ADDR_FSEL0 && a < `DDIO_ADDR_FAST_MODE;
    wire [7:0] fsel_off = a - `DDIO_ADDR_FSEL0;
    wire [1:0] fsel_idx = fsel_off[1:0];
    wire dly_hit = a[7:4] == `DDIO_ADDR_DELAY_HI && a[3:0] < 4'hc;
    wire [2:0] dly_idx = a[3:1];
    wire [15:0] wv = bus_i.wdata;
    // The fast_input_b bit sits at bit 8, so the software field is not contiguous.
    wire [5:0] wv_bits = {wv[`DDIO_VIRT_B_BIT], wv[`DDIO_VIRT_A_BIT:0]};
    wire [15:0] virt_en_rd = {7'h00, virt_en_reg[5], 3'h0, virt_en_reg[4:0]};
    wire [15:0] virt_val_rd = {7'h00, virt_val_reg[5], 3'h0, virt_val_reg[4:0]};
    wire [15:0] dly_rd = a[0] ? off_dly_reg[dly_idx] : on_dly_reg[dly_idx];
    wire [15:0] rd_mux =
        (a == `DDIO_ADDR_FILTER) ? filter_time_reg :
        (a == `DDIO_ADDR_VIRT_EN) ? virt_en_rd :
        (a == `DDIO_ADDR_VIRT_VAL) ? virt_val_rd :
        (a == `DDIO_ADDR_WIRING) ? {14'h0000, wiring_reg} :
        (a == `DDIO_ADDR_POLARITY) ? {10'h000, polarity_reg} :
        (a == `DDIO_ADDR_FAST_MODE) ? {15'h0000, fast_mode_reg} :
        fsel_hit ? {10'h000, fsel_reg[fsel_idx]} :
        dly_hit ? dly_rd :
        (a == `DDIO_ADDR_SNAPSHOT) ? {10'h000, snap_reg} :
        (a == `DDIO_ADDR_LIVE) ? {10'h000, dly_reg} :
        16'h0000;

    // Pins are asynchronous to clk_i; only the second stage is read.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= 6'h00;
            sync_reg <= 6'h00;
        end else begin
            meta_reg <= pins_i;
            sync_reg <= meta_reg;
        end
    end

    // One millisecond enable pulse shared by the filters and delays.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= tick_cnt_reg == 32'(MS_CYCLES - 1);
            tick_cnt_reg <= (tick_cnt_reg == 32'(MS_CYCLES - 1)) ? 32'h0 : tick_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            filter_time_reg <= `DDIO_FILTER_RST;
            virt_en_reg <= 6'h00;
            virt_val_reg <= 6'h00;
            wiring_reg <= 2'h0;
            polarity_reg <= 6'h00;
            fast_mode_reg <= 1'b0;
        end else begin
            if (wr_filter) filter_time_reg <= clamp(wv, `DDIO_FILTER_MAX);
            if (wr_virt_en) virt_en_reg <= wv_bits;
            if (wr_virt_val) virt_val_reg <= wv_bits;
            if (wr_wiring) wiring_reg <= wv[1:0];
            if (wr_polarity) polarity_reg <= wv[5:0];
            if (wr_fast) fast_mode_reg <= wv[0];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= 16'h0000;
            fault_q_reg <= 1'b0;
            snap_reg <= 6'h00;
        end else begin
            rdata_reg <= bus_i.rd ? rd_mux : 16'h0000;
            fault_q_reg <= status_i.fault;
            if (status_i.fault && !fault_q_reg) snap_reg <= dly_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NI; gi++) begin : g_in
            logic [15:0] fcnt_reg;
            logic [15:0] dcnt_reg;
            wire fdiff = sync_reg[gi] != filt_reg[gi];
            wire ddiff = tgt[gi] != dly_reg[gi];
            wire [15:0] dlim = tgt[gi] ? on_dly_reg[gi] : off_dly_reg[gi];
            wire dly_wr = bus_i.wr && dly_hit && dly_idx == 3'(gi);
            assign filt_accept[gi] = fdiff && fcnt_reg >= filter_time_reg;
            // Polarity acts on the pin path; a virtual value is taken as written.
            assign tgt[gi] = virt_en_reg[gi] ? virt_val_reg[gi] :
                             filt_reg[gi] ^ polarity_reg[gi];
            assign dly_accept[gi] = ddiff && dcnt_reg >= dlim;
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    fcnt_reg <= 16'h0000;
                    filt_reg[gi] <= 1'b0;
                end else begin
                    filt_reg[gi] <= filt_accept[gi] ? sync_reg[gi] : filt_reg[gi];
                    if (!fdiff || filt_accept[gi]) fcnt_reg <= 16'h0000;
                    else if (tick_reg && fcnt_reg != 16'hffff) fcnt_reg <= fcnt_reg + 16'h1;
                end
            end
            // A change that reverts restarts the count, so a change passes only once it has held through dlim ticks of the shared millisecond pulse.
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    dcnt_reg <= 16'h0000;
                    dly_reg[gi] <= 1'b0;
                end else begin
                    dly_reg[gi] <= dly_accept[gi] ? tgt[gi] : dly_reg[gi];
                    if (!ddiff || dly_accept[gi]) dcnt_reg <= 16'h0000;
                    else if (tick_reg && dcnt_reg != 16'hffff) dcnt_reg <= dcnt_reg + 16'h1;
                end
            end
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    on_dly_reg[gi] <= 16'h0000;
                    off_dly_reg[gi] <= 16'h0000;
                end else if (dly_wr && !a[0]) begin
                    on_dly_reg[gi] <= clamp(wv, `DDIO_DELAY_MAX);
                end else if (dly_wr) begin
                    off_dly_reg[gi] <= clamp(wv, `DDIO_DELAY_MAX);
                end
            end
        end
        for (gi = 0; gi < NO; gi++) begin : g_out
            wire sel_wr = bus_i.wr && fsel_hit && fsel_idx == 2'(gi);
            wire pulse_path = (gi == NO - 1) && fast_mode_reg;
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    fsel_reg[gi] <= `DDIO_FN_NONE;
                    out_reg[gi] <= 1'b0;
                end else begin
                    if (sel_wr) fsel_reg[gi] <= wv[5:0];
                    out_reg[gi] <= pulse_path ? pulse_i :
                                   fn_active(fsel_reg[gi], status_i);
                end
            end
        end
    endgenerate

    assign rdata_o = rdata_reg;
    assign cond_inputs_o = dly_reg;
    assign wiring_mode_o = wiring_reg;
    assign relay_one_o = out_reg[0];
    assign relay_two_o = out_reg[1];
    assign collector_output_o = out_reg[2];
    assign fast_pulse_out_o = out_reg[3];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_mode_write;
        bus_i.wr && bus_i.addr == `DDIO_ADDR_WIRING;
    endsequence
    sequence s_live_read;
        bus_i.rd && bus_i.addr == `DDIO_ADDR_LIVE;
    endsequence
    sequence s_fault_rise;
        status_i.fault && !fault_q_reg;
    endsequence

    property p_filter_zero;
        filter_time_reg == 16'h0000 && sync_reg[0] != filt_reg[0] |=> filt_reg[0] == $past(sync_reg[0]);
    endproperty
    a_filter_zero: assert property (p_filter_zero) else $error("zero filter did not pass input");
    property p_virtual;
        virt_en_reg[0] && on_dly_reg[0] == 16'h0000 && off_dly_reg[0] == 16'h0000 |=>
            cond_inputs_o[0] == $past(virt_val_reg[0]);
    endproperty
    a_virtual: assert property (p_virtual) else $error("virtual value not selected");
    property p_mode;
        s_mode_write |=> wiring_mode_o == $past(bus_i.wdata[1:0]);
    endproperty
    a_mode: assert property (p_mode) else $error("wiring mode not stored");
    property p_snapshot;
        s_fault_rise |=> snap_reg == $past(dly_reg);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("fault snapshot wrong");
    property p_live;
        s_live_read |=> rdata_o == {10'h000, $past(dly_reg)};
    endproperty
    a_live: assert property (p_live) else $error("live state readback wrong");
    property p_none;
        fsel_reg[0] == `DDIO_FN_NONE ##1 fsel_reg[0] == `DDIO_FN_NONE |-> !relay_one_o;
    endproperty
    a_none: assert property (p_none) else $error("unassigned output driven");
    property p_fault_out;
        fsel_reg[1] == `DDIO_FN_FAULT && status_i.fault |=> relay_two_o;
    endproperty
    a_fault_out: assert property (p_fault_out) else $error("fault output missing");
    property p_zero;
        fsel_reg[2] == `DDIO_FN_ZERO |=>
            collector_output_o == ($past(!status_i.freq_out) && $past(status_i.ref_zero));
    endproperty
    a_zero: assert property (p_zero) else $error("zero speed output wrong");
    property p_hold;
        $changed(dly_reg[0]) |-> $past(tgt[0]) != $past(dly_reg[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("delayed state moved without cause");
    property p_pulse;
        fast_mode_reg |=> fast_pulse_out_o == $past(pulse_i);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse mode not followed");

    // Timing checks watch input zero, the zero-delay check input one; the other inputs share its generate body.
    sequence s_filter_write;
        bus_i.wr && bus_i.addr == `DDIO_ADDR_FILTER;
    endsequence
    sequence s_virt_write;
        bus_i.wr && bus_i.addr == `DDIO_ADDR_VIRT_EN;
    endsequence
    sequence s_fsel_write;
        bus_i.wr && bus_i.addr == `DDIO_ADDR_FSEL0;
    endsequence
    sequence s_snap_read;
        bus_i.rd && bus_i.addr == `DDIO_ADDR_SNAPSHOT;
    endsequence
    property p_filter_clamp;
        s_filter_write |=> filter_time_reg <= `DDIO_FILTER_MAX;
    endproperty
    a_filter_clamp: assert property (p_filter_clamp) else $error("filter over limit");
    property p_filter_hold;
        $changed(filt_reg[0]) |-> $past(g_in[0].fcnt_reg) >= $past(filter_time_reg);
    endproperty
    a_filter_hold: assert property (p_filter_hold) else $error("filter early");
    property p_tick;
        tick_reg |=> !tick_reg;
    endproperty
    a_tick: assert property (p_tick) else $error("tick longer than one cycle");
    property p_sync;
        sync_reg == $past(meta_reg);
    endproperty
    a_sync: assert property (p_sync) else $error("sync stage skipped");
    property p_virt_bits;
        s_virt_write |=> virt_en_reg[4] == $past(bus_i.wdata[`DDIO_VIRT_A_BIT]) &&
            virt_en_reg[5] == $past(bus_i.wdata[`DDIO_VIRT_B_BIT]);
    endproperty
    a_virt_bits: assert property (p_virt_bits) else $error("virtual bit layout wrong");
    property p_no_delay;
        on_dly_reg[1] == 16'h0000 && off_dly_reg[1] == 16'h0000 |=> dly_reg[1] == $past(tgt[1]);
    endproperty
    a_no_delay: assert property (p_no_delay) else $error("zero delay held input");
    property p_on_delay;
        $rose(dly_reg[0]) |-> $past(g_in[0].dcnt_reg) >= $past(on_dly_reg[0]);
    endproperty
    a_on_delay: assert property (p_on_delay) else $error("switch-on too early");
    property p_off_delay;
        $fell(dly_reg[0]) |-> $past(g_in[0].dcnt_reg) >= $past(off_dly_reg[0]);
    endproperty
    a_off_delay: assert property (p_off_delay) else $error("switch-off too early");
    property p_dly_restart;
        tgt[0] == dly_reg[0] |=> g_in[0].dcnt_reg == 16'h0000;
    endproperty
    a_dly_restart: assert property (p_dly_restart) else $error("delay count kept");
    property p_snap_hold;
        !(status_i.fault && !fault_q_reg) |=> $stable(snap_reg);
    endproperty
    a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved");
    property p_snap_read;
        s_snap_read |=> rdata_o == {10'h000, $past(snap_reg)};
    endproperty
    a_snap_read: assert property (p_snap_read) else $error("snapshot readback wrong");
    property p_rdata_idle;
        !bus_i.rd |=> rdata_o == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");
    property p_fsel_store;
        s_fsel_write |=> fsel_reg[0] == $past(bus_i.wdata[5:0]);
    endproperty
    a_fsel_store: assert property (p_fsel_store) else $error("select not stored");
    property p_same_code;
        fsel_reg[0] == fsel_reg[1] && fsel_reg[1] == fsel_reg[2] |=>
            relay_one_o == relay_two_o && relay_two_o == collector_output_o;
    endproperty
    a_same_code: assert property (p_same_code) else $error("shared code differs");
    property p_fast_digital;
        !fast_mode_reg && fsel_reg[3] == fsel_reg[0] |=> fast_pulse_out_o == relay_one_o;
    endproperty
    a_fast_digital: assert property (p_fast_digital) else $error("fast output wrong");
    property p_run;
        fsel_reg[0] == `DDIO_FN_RUN |=>
            relay_one_o == ($past(status_i.running) && $past(status_i.freq_out));
    endproperty
    a_run: assert property (p_run) else $error("running output wrong");
    property p_upper;
        fsel_reg[1] == `DDIO_FN_UPPER |=> relay_two_o == $past(status_i.at_upper);
    endproperty
    a_upper: assert property (p_upper) else $error("upper limit output wrong");
    property p_lower;
        fsel_reg[2] == `DDIO_FN_LOWER |=> collector_output_o == $past(status_i.at_lower);
    endproperty
    a_lower: assert property (p_lower) else $error("lower limit output wrong");
    property p_ready;
        fsel_reg[0] == `DDIO_FN_READY |=>
            relay_one_o == ($past(status_i.main_pwr) && $past(status_i.ctrl_pwr) &&
            !$past(status_i.prot_active));
    endproperty
    a_ready: assert property (p_ready) else $error("ready output wrong");
    property p_preexc;
        fsel_reg[1] == `DDIO_FN_PREEXC |=> relay_two_o == $past(status_i.preexcite);
    endproperty
    a_preexc: assert property (p_preexc) else $error("pre-excite output wrong");
    property p_ovld;
        fsel_reg[2] == `DDIO_FN_OVLD |=> collector_output_o == $past(status_i.overload_pre);
    endproperty
    a_ovld: assert property (p_ovld) else $error("overload output wrong");
    property p_polarity;
        !virt_en_reg[1] && polarity_reg[1] |-> tgt[1] != filt_reg[1];
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity not applied");
    property p_virt_b;
        virt_en_reg[5] && on_dly_reg[5] == 16'h0000 && off_dly_reg[5] == 16'h0000 |=>
            cond_inputs_o[5] == $past(virt_val_reg[5]);
    endproperty
    a_virt_b: assert property (p_virt_b) else $error("virtual value not reported");
endmodule

// [verif/ddio_field_model.sv]
`timescale 1ns/1ps
module ddio_field_model (
    input wire logic clk_i,
    output logic [5:0] pins_o
);
    // Dry contacts on the terminal block; a worn contact chatters before it settles.
    initial pins_o = 6'h00;
    task automatic press(input int idx, input logic val, input int chatter);
        for (int k = 0; k < chatter; k++) begin
            @(posedge clk_i);
            pins_o[idx] <= ~pins_o[idx];
        end
        @(posedge clk_i);
        pins_o[idx] <= val;
    endtask
endmodule

// [verif/ddio_top_tb.sv]
`timescale 1ns/1ps
module ddio_top_tb;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    ddio_pkg::ddio_bus_s bus = '0;
    ddio_pkg::ddio_status_s st = '0;
    logic pulse = 1'b0;
    logic [15:0] rdata;
    logic [5:0] pins;
    logic [5:0] cond;
    logic [1:0] wmode;
    wire [3:0] outs;
    int errors = 0;
    int cmp_count = 0;
    int codes[11] = '{1, 2, 3, 4, 5, 9, 10, 11, 12, 13, 14};
    always #2.5 clk_i = ~clk_i;
    // A millisecond is shrunk to four cycles so that delays of several ms stay short.
    ddio_top #(.MS_CYCLES(4)) i_ddio_top (.clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus),
        .rdata_o(rdata), .pins_i(pins), .status_i(st), .pulse_i(pulse),
        .cond_inputs_o(cond), .wiring_mode_o(wmode), .relay_one_o(outs[0]),
        .relay_two_o(outs[1]), .collector_output_o(outs[2]), .fast_pulse_out_o(outs[3]));
    ddio_field_model i_ddio_field_model (.clk_i(clk_i), .pins_o(pins));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge clk_i);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_i);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1;
        chk($sformatf("reg_%h", a), e, rdata);
    endtask
    task automatic stay(input int b, input logic v, input int n);
        repeat (n) begin
            @(posedge clk_i);
            #1;
            chk("cond_hold", {15'h0, v}, {15'h0, cond[b]});
        end
    endtask
    // The wait is bounded so that a dead input path fails here, not at the watchdog.
    task automatic wait_in(input int b, input logic v, input int lim);
        int n = 0;
        while (cond[b] !== v && n < lim) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("cond_wait", {15'h0, v}, {15'h0, cond[b]});
    endtask
    function automatic ddio_pkg::ddio_status_s mk(input int c, input logic on);
        ddio_pkg::ddio_status_s s;
        s = '0;
        s.freq_out = 1'b1;
        case (c)
            1: s.running = on;
            2: begin
                s.fwd = 1'b1;
                s.freq_out = on;
            end
            3: s.rev = on;
            4: begin
                s.jog = 1'b1;
                s.freq_out = on;
            end
            5: s.fault = on;
            9: begin
                s.freq_out = 1'b0;
                s.ref_zero = on;
            end
            10: s.at_upper = on;
            11: s.at_lower = on;
            12: begin
                s.main_pwr = 1'b1;
                s.ctrl_pwr = 1'b1;
                s.prot_active = ~on;
            end
            13: s.preexcite = on;
            default: s.overload_pre = on;
        endcase
        return s;
    endfunction
    task automatic t_regs;
        rchk(8'h00, 16'h000a);
        rchk(8'h01, 16'h0000);
        rchk(8'h20, 16'h0000);
        rchk(8'h21, 16'h0000);
        rchk(8'h3f, 16'h0000);
        wr(8'h00, 16'hffff);
        rchk(8'h00, 16'h03e8);
        wr(8'h12, 16'hffff);
        rchk(8'h12, 16'hc350);
        wr(8'h13, 16'hffff);
        rchk(8'h13, 16'hc350);
        wr(8'h12, 16'h0000);
        wr(8'h13, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            wr(8'h02, 16'(c));
            chk("wiring_mode", 16'(c), {14'h0, wmode});
        end
        $display("test regs done");
    endtask
    task automatic t_filter;
        wr(8'h00, 16'h0002);
        i_ddio_field_model.press(0, 1'b0, 3);
        stay(0, 1'b0, 20);
        i_ddio_field_model.press(0, 1'b1, 0);
        stay(0, 1'b0, 3);
        wait_in(0, 1'b1, 16);
        i_ddio_field_model.press(0, 1'b0, 0);
        wait_in(0, 1'b0, 16);
        wr(8'h00, 16'h0000);
        $display("test filter done");
    endtask
    task automatic t_delay;
        wr(8'h10, 16'h0003);
        wr(8'h11, 16'h0002);
        i_ddio_field_model.press(0, 1'b1, 0);
        stay(0, 1'b0, 4);
        i_ddio_field_model.press(0, 1'b0, 0);
        stay(0, 1'b0, 20);
        i_ddio_field_model.press(0, 1'b1, 0);
        stay(0, 1'b0, 8);
        wait_in(0, 1'b1, 12);
        i_ddio_field_model.press(0, 1'b0, 0);
        stay(0, 1'b1, 5);
        wait_in(0, 1'b0, 12);
        wr(8'h10, 16'h0000);
        wr(8'h11, 16'h0000);
        $display("test delay done");
    endtask
    task automatic t_virtual;
        wr(8'h01, 16'h0111);
        wr(8'h04, 16'h0111);
        repeat (6) @(posedge clk_i);
        #1;
        chk("cond_virtual", 16'h0031, {10'h0, cond});
        rchk(8'h21, 16'h0031);
        rchk(8'h01, 16'h0111);
        wr(8'h01, 16'h0000);
        wr(8'h04, 16'h0000);
        wr(8'h03, 16'h0002);
        repeat (6) @(posedge clk_i);
        #1;
        chk("cond_polarity", 16'h0002, {10'h0, cond});
        wr(8'h03, 16'h0000);
        $display("test virtual and polarity done");
    endtask
    task automatic t_snapshot;
        i_ddio_field_model.press(2, 1'b1, 0);
        wait_in(2, 1'b1, 8);
        @(posedge clk_i);
        st.fault <= 1'b1;
        i_ddio_field_model.press(2, 1'b0, 0);
        wait_in(2, 1'b0, 8);
        rchk(8'h20, 16'h0004);
        @(posedge clk_i);
        st.fault <= 1'b0;
        $display("test snapshot done");
    endtask
    task automatic t_outputs;
        foreach (codes[i]) begin
            for (int k = 0; k < 4; k++) wr(8'h05 + 8'(k), 16'(codes[i]));
            for (int on = 1; on >= 0; on--) begin
                @(posedge clk_i);
                st <= mk(codes[i], on[0]);
                repeat (3) @(posedge clk_i);
                #1;
                chk($sformatf("outs_code_%0d", codes[i]), on ? 16'h000f : 16'h0000,
                    {12'h0, outs});
            end
        end
        for (int k = 0; k < 4; k++) wr(8'h05 + 8'(k), 16'h0000);
        @(posedge clk_i);
        st <= '1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("outs_code_0", 16'h0000, {12'h0, outs});
        @(posedge clk_i);
        st <= '0;
        wr(8'h08, 16'h0005);
        wr(8'h09, 16'h0001);
        for (int i = 1; i < 6; i++) begin
            @(posedge clk_i);
            pulse <= i[0];
            @(posedge clk_i);
            #1;
            chk("fast_pulse", {15'h0, i[0]}, {15'h0, outs[3]});
        end
        $display("test outputs done");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        chk("outs_in_reset", 16'h0000, {4'h0, cond, wmode, outs});
        rstn_i <= 1'b1;
        t_regs();
        t_filter();
        t_delay();
        t_virtual();
        t_snapshot();
        t_outputs();
        tally_and_finish();
    end
    // The tests take a few hundred cycles; this leaves ample margin before calling a hang.
    initial begin
        #300us;
        errors++;
        tally_and_finish();
    end
endmodule
